// file: core/setpoint_write_encoder.sv
// Setpoint to write-request byte stream encoder with its register port
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1 - Digital setpoint written as coil, FC05/FC15
// R2 - 16-bit integer: one register, FC06/FC16
// R3 - 32-bit integer: two registers, FC16 only
// R4 - High word first: upper word at lower address
// R5 - Low word first: lower word at lower address
// R6 - Float: 32 bits, two registers, word order
// R7 - Requests carry configured slave and start register
// R8 - Signed two's complement, unsigned plain binary
module setpoint_write_encoder (
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic [4:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    output logic      [7:0]  tx_data_o,
    output logic             tx_valid_o,
    output logic             tx_last_o,
    input  wire logic        tx_ready_i,
    output logic             busy_o
);

    setpoint_frame_pkg::state_t s_r;
    setpoint_frame_pkg::state_t s_nxt;
    logic                       start_acc;
    logic                       last_idx;

    // Snapshot of everything a request needs, so software may rewrite
    // the registers while a frame is still going out
    function automatic setpoint_frame_pkg::frame_t build_f(
        input setpoint_frame_pkg::cfg_t cfg,
        input logic [7:0]               slave,
        input logic [15:0]              start,
        input logic [31:0]              value
    );
        setpoint_frame_pkg::frame_t f;
        f       = '0;
        f.slave = slave; // R7
        f.start = start; // R7
        if (cfg.fmt == setpoint_frame_pkg::FMT_DIGITAL) begin
            if (cfg.multi) begin // R1
                f.fc  = setpoint_frame_pkg::FC_COIL_MANY;
                f.qty = setpoint_frame_pkg::QTY_ONE;
                f.bc  = setpoint_frame_pkg::BC_COIL;
                f.w0  = {7'h00, value[0], 8'h00};
                f.len = setpoint_frame_pkg::LEN_COIL_MANY;
            end else begin
                f.fc  = setpoint_frame_pkg::FC_COIL_ONE;
                f.w0  = value[0] ? setpoint_frame_pkg::COIL_ON : setpoint_frame_pkg::COIL_OFF;
                f.len = setpoint_frame_pkg::LEN_SINGLE;
            end
        end else if (cfg.wide || cfg.fmt == setpoint_frame_pkg::FMT_FLOAT) begin
            // Two registers always go as one multiple-register write
            f.fc  = setpoint_frame_pkg::FC_REG_MANY; // R3 R6
            f.qty = setpoint_frame_pkg::QTY_TWO;
            f.bc  = setpoint_frame_pkg::BC_TWO_REG;
            f.len = setpoint_frame_pkg::LEN_REG_MANY2;
            if (cfg.low_word_first) begin
                f.w0 = value[15:0]; // R5
                f.w1 = value[31:16]; // R5
            end else begin
                f.w0 = value[31:16]; // R4
                f.w1 = value[15:0]; // R4
            end
        end else begin
            // Signed and unsigned share bits; only the low 16 are sent
            f.w0 = value[15:0]; // R8
            if (cfg.multi) begin // R2
                f.fc  = setpoint_frame_pkg::FC_REG_MANY;
                f.qty = setpoint_frame_pkg::QTY_ONE;
                f.bc  = setpoint_frame_pkg::BC_ONE_REG;
                f.len = setpoint_frame_pkg::LEN_REG_MANY1;
            end else begin
                f.fc  = setpoint_frame_pkg::FC_REG_ONE;
                f.len = setpoint_frame_pkg::LEN_SINGLE;
            end
        end
        return f;
    endfunction : build_f

    function automatic logic [7:0] byte_f(
        input setpoint_frame_pkg::frame_t f,
        input logic [3:0]                 idx
    );
        logic single;
        single = (f.len == setpoint_frame_pkg::LEN_SINGLE);
        unique case (idx)
            4'h0:    byte_f = f.slave;
            4'h1:    byte_f = f.fc;
            4'h2:    byte_f = f.start[15:8];
            4'h3:    byte_f = f.start[7:0];
            4'h4:    byte_f = single ? f.w0[15:8] : 8'h00;
            4'h5:    byte_f = single ? f.w0[7:0] : f.qty;
            4'h6:    byte_f = f.bc;
            4'h7:    byte_f = f.w0[15:8];
            4'h8:    byte_f = f.w0[7:0];
            4'h9:    byte_f = f.w1[15:8];
            4'hA:    byte_f = f.w1[7:0];
            default: byte_f = 8'h00;
        endcase
    endfunction : byte_f

    assign start_acc = reg_wr_i && reg_addr_i == setpoint_frame_pkg::OFS_CTRL
                       && reg_wdata_i[setpoint_frame_pkg::CTRL_START_BIT]
                       && s_r.fsm == setpoint_frame_pkg::ST_IDLE;
    assign last_idx  = s_r.idx == 4'(s_r.frm.len - 4'h1);

    always_comb begin
        s_nxt       = s_r;
        s_nxt.rdata = 32'h0000_0000;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                setpoint_frame_pkg::OFS_CFG: begin
                    s_nxt.cfg = setpoint_frame_pkg::cfg_t'(
                        reg_wdata_i[setpoint_frame_pkg::CFG_WIDTH-1:0]);
                end
                setpoint_frame_pkg::OFS_TARGET: begin
                    s_nxt.slave = reg_wdata_i[7:0];
                    s_nxt.start = reg_wdata_i[setpoint_frame_pkg::TARGET_START_LSB +: 16];
                end
                setpoint_frame_pkg::OFS_VALUE: begin
                    s_nxt.value = reg_wdata_i;
                end
                default: begin
                end
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                setpoint_frame_pkg::OFS_CTRL:   s_nxt.rdata = {31'h0,
                                                               s_r.fsm == setpoint_frame_pkg::ST_SEND};
                setpoint_frame_pkg::OFS_CFG:    s_nxt.rdata = {27'h0, s_r.cfg};
                setpoint_frame_pkg::OFS_TARGET: s_nxt.rdata = {s_r.start, 8'h00, s_r.slave};
                setpoint_frame_pkg::OFS_VALUE:  s_nxt.rdata = s_r.value;
                setpoint_frame_pkg::OFS_STATUS: s_nxt.rdata = {16'h0, s_r.sent, 7'h00,
                                                               s_r.fsm == setpoint_frame_pkg::ST_SEND};
                default:                        s_nxt.rdata = 32'h0000_0000;
            endcase
        end
        unique case (s_r.fsm)
            setpoint_frame_pkg::ST_IDLE: begin
                // The frame is built from register contents before this write lands
                if (start_acc) begin
                    s_nxt.frm = build_f(s_r.cfg, s_r.slave, s_r.start, s_r.value);
                    s_nxt.idx = 4'h0;
                    s_nxt.fsm = setpoint_frame_pkg::ST_SEND;
                end
            end
            setpoint_frame_pkg::ST_SEND: begin
                if (tx_ready_i) begin
                    if (last_idx) begin
                        s_nxt.fsm  = setpoint_frame_pkg::ST_IDLE;
                        s_nxt.sent = s_r.sent + 8'h01;
                    end else begin
                        s_nxt.idx = s_r.idx + 4'h1;
                    end
                end
            end
        endcase
        s_nxt.tx_byte = byte_f(s_nxt.frm, s_nxt.idx);
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r       <= '0;
            s_r.fsm   <= setpoint_frame_pkg::ST_IDLE;
            s_r.cfg   <= setpoint_frame_pkg::cfg_t'(setpoint_frame_pkg::CFG_RST);
            s_r.slave <= setpoint_frame_pkg::SLAVE_RST;
            s_r.start <= setpoint_frame_pkg::START_RST;
            s_r.value <= setpoint_frame_pkg::VALUE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata_o = s_r.rdata;
    assign tx_data_o   = s_r.tx_byte;
    assign tx_valid_o  = s_r.fsm == setpoint_frame_pkg::ST_SEND;
    assign tx_last_o   = tx_valid_o && last_idx;
    assign busy_o      = tx_valid_o;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    AST_DIGITAL_COIL: assert property ( // R1
        start_acc && s_r.cfg.fmt == setpoint_frame_pkg::FMT_DIGITAL
        |=> s_r.frm.fc == ($past(s_r.cfg.multi) ? 8'h0F : 8'h05)
            && s_r.frm.w0[15:8] == ($past(s_r.cfg.multi) ? {7'h00, $past(s_r.value[0])}
                                    : ($past(s_r.value[0]) ? 8'hFF : 8'h00)))
        else $error("digital setpoint not encoded as coil write");

    AST_INT16_ONE_REG: assert property ( // R2
        start_acc && !s_r.cfg.wide && (s_r.cfg.fmt == setpoint_frame_pkg::FMT_SIGNED
        || s_r.cfg.fmt == setpoint_frame_pkg::FMT_UNSIGNED)
        |=> (s_r.frm.fc == 8'h06 && s_r.frm.len == 4'h6)
            || (s_r.frm.fc == 8'h10 && s_r.frm.qty == 8'h01 && s_r.frm.len == 4'h9))
        else $error("16-bit setpoint not a one-register write");

    AST_INT32_TWO_REG: assert property ( // R3
        start_acc && s_r.cfg.wide && s_r.cfg.fmt != setpoint_frame_pkg::FMT_DIGITAL
        |=> s_r.frm.fc == 8'h10 && s_r.frm.qty == 8'h02 && s_r.frm.bc == 8'h04
            && s_r.frm.len == 4'hB)
        else $error("32-bit setpoint not a two-register multiple write");

    AST_HIGH_FIRST: assert property ( // R4
        start_acc && !s_r.cfg.low_word_first
        && (s_r.cfg.wide || s_r.cfg.fmt == setpoint_frame_pkg::FMT_FLOAT)
        && s_r.cfg.fmt != setpoint_frame_pkg::FMT_DIGITAL
        |=> s_r.frm.w0 == $past(s_r.value[31:16]) && s_r.frm.w1 == $past(s_r.value[15:0]))
        else $error("high word not at lower register address");

    AST_LOW_FIRST: assert property ( // R5
        start_acc && s_r.cfg.low_word_first && s_r.cfg.fmt != setpoint_frame_pkg::FMT_DIGITAL
        && (s_r.cfg.wide || s_r.cfg.fmt == setpoint_frame_pkg::FMT_FLOAT)
        |=> s_r.frm.w0 == $past(s_r.value[15:0]) && s_r.frm.w1 == $past(s_r.value[31:16]))
        else $error("low word not at lower register address");

    AST_FLOAT_TWO_REG: assert property ( // R6
        start_acc && s_r.cfg.fmt == setpoint_frame_pkg::FMT_FLOAT
        |=> s_r.frm.fc == 8'h10 && s_r.frm.qty == 8'h02 && s_r.frm.bc == 8'h04
            && s_r.frm.len == 4'hB && tx_data_o == s_r.frm.slave)
        else $error("float setpoint not a two-register write");

    AST_TARGET_BYTES: assert property ( // R7
        start_acc ##1 tx_ready_i ##1 tx_ready_i
        |-> ##1 $past(tx_data_o, 2) == $past(s_r.slave, 3)
            && tx_data_o == $past(s_r.start[15:8], 3))
        else $error("frame does not open with slave and start address");

    AST_SIGNED_BITS: assert property ( // R8
        start_acc && !s_r.cfg.wide && s_r.cfg.fmt == setpoint_frame_pkg::FMT_SIGNED
        |=> s_r.frm.w0 == $past(s_r.value[15:0]))
        else $error("signed 16-bit value not sent as two's complement");

    AST_HOLD_UNDER_STALL: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("byte changed while sink stalled");

    AST_UNSIGNED_BITS: assert property ( // R8
        start_acc && !s_r.cfg.wide && s_r.cfg.fmt == setpoint_frame_pkg::FMT_UNSIGNED
        |=> s_r.frm.w0 == $past(s_r.value[15:0]))
        else $error("unsigned 16-bit value not sent as plain binary");

    AST_FIRST_BYTE_SLAVE: assert property ( // R7
        start_acc
        |=> tx_valid_o && tx_data_o == $past(s_r.slave))
        else $error("frame does not open with the slave address");

    AST_START_LOW_BYTE: assert property ( // R7
        start_acc ##1 tx_ready_i ##1 tx_ready_i ##1 tx_ready_i
        |-> ##1 tx_data_o == $past(s_r.start[7:0], 4))
        else $error("fourth byte is not the low start address");

    AST_DIGITAL_LENGTH: assert property ( // R1
        start_acc && s_r.cfg.fmt == setpoint_frame_pkg::FMT_DIGITAL
        |=> s_r.frm.len == ($past(s_r.cfg.multi) ? 4'h8 : 4'h6))
        else $error("coil write has wrong length");

    AST_TWO_REG_CODE: assert property ( // R3
        tx_valid_o && s_r.frm.qty == 8'h02
        |-> s_r.frm.fc == 8'h10 && s_r.frm.bc == 8'h04)
        else $error("two-register frame not a multiple write");

    AST_LEGAL_CODE: assert property (
        tx_valid_o
        |-> s_r.frm.fc inside {8'h05, 8'h0F, 8'h06, 8'h10})
        else $error("frame carries an unknown write code");

    AST_LEGAL_LENGTH: assert property (
        tx_valid_o
        |-> s_r.frm.len inside {4'h6, 4'h8, 4'h9, 4'hB})
        else $error("frame has an illegal length");

    AST_VALID_DROPS_AFTER_LAST: assert property (
        tx_last_o && tx_ready_i
        |=> !tx_valid_o)
        else $error("valid stayed high after the last byte");

    AST_SENT_COUNT: assert property (
        tx_last_o && tx_ready_i
        |=> s_r.sent == $past(s_r.sent) + 8'h01)
        else $error("frame counter did not advance");

    AST_FRAME_HELD_WHILE_SENDING: assert property (
        tx_valid_o
        |=> $stable(s_r.frm))
        else $error("frame snapshot changed while sending");

    AST_FRAME_NEEDS_START: assert property (
        $rose(tx_valid_o)
        |-> $past(start_acc))
        else $error("frame began without a start write");

    AST_READ_ONE_CYCLE: assert property (
        !reg_rd_i
        |=> reg_rdata_o == 32'h0000_0000)
        else $error("read data outside its cycle");

endmodule : setpoint_write_encoder

`default_nettype wire

// file: core/setpoint_frame_pkg.sv
// Constants, types and register map of the setpoint write encoder
package setpoint_frame_pkg;

    // Register byte offsets, one aligned 32-bit word each
    localparam logic [4:0]  OFS_CTRL     = 5'h00;
    localparam logic [4:0]  OFS_CFG      = 5'h04;
    localparam logic [4:0]  OFS_TARGET   = 5'h08;
    localparam logic [4:0]  OFS_VALUE    = 5'h0C;
    localparam logic [4:0]  OFS_STATUS   = 5'h10;

    // Field positions
    localparam int          CTRL_START_BIT   = 0;
    localparam int          CFG_WIDTH        = 5;
    localparam int          TARGET_START_LSB = 16;

    // Values after reset
    localparam logic [4:0]  CFG_RST      = 5'h00;
    localparam logic [7:0]  SLAVE_RST    = 8'h01;
    localparam logic [15:0] START_RST    = 16'h0000;
    localparam logic [31:0] VALUE_RST    = 32'h0000_0000;

    // Write function codes
    localparam logic [7:0]  FC_COIL_ONE  = 8'h05;
    localparam logic [7:0]  FC_COIL_MANY = 8'h0F;
    localparam logic [7:0]  FC_REG_ONE   = 8'h06;
    localparam logic [7:0]  FC_REG_MANY  = 8'h10;

    localparam logic [15:0] COIL_ON      = 16'hFF00;
    localparam logic [15:0] COIL_OFF     = 16'h0000;

    // Quantities, byte counts and frame lengths in bytes (no CRC)
    localparam logic [7:0]  QTY_ONE      = 8'h01;
    localparam logic [7:0]  QTY_TWO      = 8'h02;
    localparam logic [7:0]  BC_COIL      = 8'h01;
    localparam logic [7:0]  BC_ONE_REG   = 8'h02;
    localparam logic [7:0]  BC_TWO_REG   = 8'h04;
    localparam logic [3:0]  LEN_SINGLE   = 4'h6;
    localparam logic [3:0]  LEN_COIL_MANY = 4'h8;
    localparam logic [3:0]  LEN_REG_MANY1 = 4'h9;
    localparam logic [3:0]  LEN_REG_MANY2 = 4'hB;

    typedef enum logic [1:0] {
        FMT_DIGITAL  = 2'h0,
        FMT_SIGNED   = 2'h1,
        FMT_UNSIGNED = 2'h2,
        FMT_FLOAT    = 2'h3
    } fmt_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } fsm_t;

    typedef struct packed {
        logic multi;
        logic low_word_first;
        logic wide;
        fmt_t fmt;
    } cfg_t;

    typedef struct packed {
        logic [7:0]  slave;
        logic [7:0]  fc;
        logic [15:0] start;
        logic [15:0] w0;
        logic [15:0] w1;
        logic [7:0]  qty;
        logic [7:0]  bc;
        logic [3:0]  len;
    } frame_t;

    typedef struct packed {
        fsm_t        fsm;
        cfg_t        cfg;
        logic [7:0]  slave;
        logic [15:0] start;
        logic [31:0] value;
        frame_t      frm;
        logic [3:0]  idx;
        logic [7:0]  tx_byte;
        logic [31:0] rdata;
        logic [7:0]  sent;
    } state_t;

endpackage : setpoint_frame_pkg

// file: tb/frame_sink.sv
// Byte sink standing in for the serial transmit path behind the encoder
`timescale 1ns/1ps
`default_nettype none
module frame_sink (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    input  wire logic       tx_last_i,
    input  wire logic       slow_i,
    output var  logic       ready_o,
    output var  logic [7:0] frames_o,
    output var  logic [7:0] nbytes_o,
    output var  logic [7:0] hold_err_o
);
    logic [7:0] mem [256];
    logic [7:0] data_q;
    logic       stall_q;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ready_o    <= 1'b0;
            frames_o   <= 8'h00;
            nbytes_o   <= 8'h00;
            hold_err_o <= 8'h00;
            stall_q    <= 1'b0;
            data_q     <= 8'h00;
        end else begin
            // Slow mode accepts every other cycle so stalled bytes get held
            ready_o <= slow_i ? ~ready_o : 1'b1;
            stall_q <= tx_valid_i && !ready_o;
            data_q  <= tx_data_i;
            if (stall_q && tx_valid_i && tx_data_i !== data_q) begin
                hold_err_o <= hold_err_o + 8'h01;
            end
            if (tx_valid_i && ready_o) begin
                mem[nbytes_o] <= tx_data_i;
                nbytes_o      <= nbytes_o + 8'h01;
                if (tx_last_i) begin
                    frames_o <= frames_o + 8'h01;
                end
            end
        end
    end
endmodule : frame_sink
`default_nettype wire

// file: tb/modbus_setpoint_write_encoder_tb.sv
// Self-checking bench for the setpoint write encoder
`timescale 1ns/1ps
`default_nettype none
module modbus_setpoint_write_encoder_tb;
    logic        clk_sys_i;
    logic        rstn_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic        slow;
    logic [4:0]  reg_addr_i;
    logic [31:0] reg_wdata_i;
    logic [31:0] reg_rdata_o;
    logic [31:0] d;
    logic [7:0]  tx_data_o;
    logic [7:0]  frames;
    logic [7:0]  nbytes;
    logic [7:0]  hold_err;
    logic [7:0]  exp_frames;
    logic        tx_valid_o;
    logic        tx_last_o;
    logic        tx_ready_i;
    logic        busy_o;
    int          err_total;
    int          tests_run;

    setpoint_write_encoder dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
        .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i), .busy_o(busy_o));
    frame_sink sink (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .tx_data_i(tx_data_o),
        .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .slow_i(slow), .ready_o(tx_ready_i),
        .frames_o(frames), .nbytes_o(nbytes), .hold_err_o(hold_err));

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic finish_test;
        $display("Counts: %0d checks, %0d errors", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("Error: %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : check

    task automatic reg_wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr_i  <= a;
        reg_wdata_i <= v;
        reg_wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [4:0] a);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : reg_rd

    task automatic wait_frame;
        for (int n = 0; n < 300 && frames !== exp_frames; n++) @(posedge clk_sys_i);
        if (frames !== exp_frames) begin
            $display("Error: frame wait expected %h seen %h", exp_frames, frames);
            err_total++;
            finish_test();
        end
        @(posedge clk_sys_i);
        #1;
    endtask : wait_frame

    // Loads one channel setup, starts it and compares the whole byte stream
    task automatic run_frame(input logic [31:0] cfg, tgt, val, input logic [7:0] exp[$]);
        logic [7:0] base;
        base = nbytes;
        reg_wr(setpoint_frame_pkg::OFS_CFG, cfg);
        reg_wr(setpoint_frame_pkg::OFS_TARGET, tgt);
        reg_wr(setpoint_frame_pkg::OFS_VALUE, val);
        reg_wr(setpoint_frame_pkg::OFS_CTRL, 32'h0000_0001);
        exp_frames = exp_frames + 8'h01;
        wait_frame();
        check("byte count", 32'(exp.size()), 32'(8'(nbytes - base)));
        foreach (exp[i]) check("frame byte", 32'(exp[i]), 32'(sink.mem[8'(base + i)]));
        check("busy after frame", 32'h0, 32'(busy_o));
        check("held byte changes", 32'h0, 32'(hold_err));
    endtask : run_frame

    task automatic test_regs;
        reg_rd(setpoint_frame_pkg::OFS_TARGET);
        check("target reset", 32'h0000_0001, d);
        reg_rd(5'h14);
        check("unmapped read", 32'h0, d);
        reg_rd(setpoint_frame_pkg::OFS_CTRL);
        check("ctrl idle", 32'h0, d);
        reg_wr(setpoint_frame_pkg::OFS_CFG, 32'h0000_001B);
        reg_rd(setpoint_frame_pkg::OFS_CFG);
        check("config readback", 32'h0000_001B, d);
        @(posedge clk_sys_i);
        #1;
        check("read data after its cycle", 32'h0, reg_rdata_o);
        reg_wr(setpoint_frame_pkg::OFS_VALUE, 32'h89AB_CDEF);
        reg_rd(setpoint_frame_pkg::OFS_VALUE);
        check("value readback", 32'h89AB_CDEF, d);
        $display("Done: register reads");
    endtask : test_regs

    task automatic test_coil;
        run_frame(32'h00, 32'h0203_0011, 32'h1, '{8'h11,8'h05,8'h02,8'h03,8'hFF,8'h00});
        run_frame(32'h00, 32'hFFFE_00F7, 32'h0, '{8'hF7,8'h05,8'hFF,8'hFE,8'h00,8'h00});
        run_frame(32'h10, 32'h0203_0011, 32'h1,
            '{8'h11,8'h0F,8'h02,8'h03,8'h00,8'h01,8'h01,8'h01});
        $display("Done: coil frames");
    endtask : test_coil

    task automatic test_reg16;
        run_frame(32'h01, 32'h0203_0011, 32'hFFFF_8001, '{8'h11,8'h06,8'h02,8'h03,8'h80,8'h01});
        run_frame(32'h12, 32'h0203_0011, 32'h0000_BEEF,
            '{8'h11,8'h10,8'h02,8'h03,8'h00,8'h01,8'h02,8'hBE,8'hEF});
        $display("Done: single register frames");
    endtask : test_reg16

    task automatic test_reg32;
        run_frame(32'h05, 32'h0203_0011, 32'hFFFE_1234, '{8'h11,8'h10,8'h02,8'h03,8'h00,
            8'h02,8'h04,8'hFF,8'hFE,8'h12,8'h34});
        run_frame(32'h0E, 32'h0203_0011, 32'h89AB_CDEF, '{8'h11,8'h10,8'h02,8'h03,8'h00,
            8'h02,8'h04,8'hCD,8'hEF,8'h89,8'hAB});
        $display("Done: two register frames");
    endtask : test_reg32

    task automatic test_float;
        slow <= 1'b1;
        run_frame(32'h03, 32'h0203_0011, 32'h3F80_0000, '{8'h11,8'h10,8'h02,8'h03,8'h00,
            8'h02,8'h04,8'h3F,8'h80,8'h00,8'h00});
        run_frame(32'h1B, 32'h0203_0011, 32'hC2F6_E979, '{8'h11,8'h10,8'h02,8'h03,8'h00,
            8'h02,8'h04,8'hE9,8'h79,8'hC2,8'hF6});
        $display("Done: float frames");
    endtask : test_float

    // A second start while sending must not queue another frame
    task automatic test_busy;
        reg_wr(setpoint_frame_pkg::OFS_CTRL, 32'h0000_0001);
        reg_rd(setpoint_frame_pkg::OFS_STATUS);
        check("status while sending", {16'h0, exp_frames, 8'h01}, d);
        reg_rd(setpoint_frame_pkg::OFS_CTRL);
        check("ctrl busy bit", 32'h1, d);
        reg_wr(setpoint_frame_pkg::OFS_CTRL, 32'h0000_0001);
        exp_frames = exp_frames + 8'h01;
        wait_frame();
        repeat (40) @(posedge clk_sys_i);
        check("frames after busy start", 32'(exp_frames), 32'(frames));
        reg_rd(setpoint_frame_pkg::OFS_STATUS);
        check("status when idle", {16'h0, exp_frames, 8'h00}, d);
        $display("Done: start while busy");
    endtask : test_busy

    initial begin
        rstn_i      = 1'b0;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        reg_addr_i  = 5'h00;
        reg_wdata_i = 32'h0;
        slow        = 1'b0;
        exp_frames  = 8'h00;
        err_total   = 0;
        tests_run   = 0;
        repeat (3) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        test_regs();
        test_coil();
        test_reg16();
        test_reg32();
        test_float();
        test_busy();
        finish_test();
    end
endmodule : modbus_setpoint_write_encoder_tb
`default_nettype wire
